// ===== isfo_checker.sv
// Concurrent checks on the APB and capture ports of isfo_top.
// Assumes ce is held high, so the one wait state is never stretched.
`timescale 1ns/100ps
module isfo_checker #(
  parameter int NUM_STREAMS = 32
) (
  // Clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // APB
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // Capture
  input wire logic [NUM_STREAMS-1:0] rx_bit,
  input wire logic [NUM_STREAMS-1:0] rx_valid,
  input wire logic [NUM_STREAMS-1:0] rx_bit0
);
  logic start_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r <= 1'h0;
    end else if (pready && pwrite && !pslverr && paddr == isfo_pkg::ADDR_CTRL) begin
      start_r <= pwdata[isfo_pkg::CTRL_START_BIT];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence
  AST_WAIT_STATE: assert property (s_setup |=> s_one_wait)
    else $error("answer not after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_QUAL: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_PRDATA_IDLE: assert property (!pready |-> prdata == isfo_pkg::DATA_ZERO)
    else $error("prdata not zero outside answer");
  AST_UNMAPPED: assert property (pready && paddr > isfo_pkg::ADDR_STAT |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_STATUS_WR: assert property (pready && pwrite && paddr == isfo_pkg::ADDR_STAT |-> pslverr)
    else $error("status write not refused");
  AST_OFS_UPPER: assert property (pready && !pwrite && paddr <= isfo_pkg::ADDR_OFS_LAST |-> !(|prdata[31:16]))
    else $error("offset word upper half not zero");
  AST_STATUS_CLR: assert property (pready && !pwrite && paddr == isfo_pkg::ADDR_STAT && !start_r |-> prdata == 32'h0)
    else $error("status not cleared while start low");
  AST_BIT0_VALID: assert property ((rx_bit0 & ~rx_valid) == '0)
    else $error("bit0 pulse without capture");
  AST_BIT_HOLD: assert property (((rx_bit ^ $past(rx_bit)) & ~rx_valid) == '0)
    else $error("captured bit moved without capture");
endmodule

bind isfo_top isfo_checker #(.NUM_STREAMS(NUM_STREAMS)) i_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_bit, .rx_valid,
  .rx_bit0
);

// ===== isfo_far_model.sv
// Far side: free master clock, frame pulse, evaluation pin and 32 streams.
// Assumes go is a one-cycle pulse; stream s shows code[s][k] in half period k.
`timescale 1ns/100ps
module isfo_far_model (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Bench control
  input  wire logic              go,
  input  wire logic [5:0]        eval_hp,
  input  wire logic [31:0][15:0] code,
  // Pins
  output logic                   master_clock_in,
  output logic                   frame_pulse_n_in,
  output logic                   frame_eval_in,
  output logic [31:0]            rx_stream_in
);
  logic [2:0] ph_r;
  logic [5:0] hc_r;
  logic [3:0] idx_r;
  logic       pend_r;
  logic       act_r;
  // Frame and eval move mid half period and data two pclk from a clock edge, so no edge races a clock edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_r             <= 3'h0;
      hc_r             <= 6'h00;
      idx_r            <= 4'h0;
      pend_r           <= 1'h0;
      act_r            <= 1'h0;
      master_clock_in  <= 1'h0;
      frame_pulse_n_in <= 1'h1;
      frame_eval_in    <= 1'h0;
    end else begin
      ph_r <= ph_r + 3'h1;
      if (ph_r == 3'h7) begin
        master_clock_in <= ~master_clock_in;
        if (act_r && hc_r != 6'h3f) hc_r <= hc_r + 6'h01;
      end
      if (go) begin
        pend_r <= 1'h1;
        act_r  <= 1'h0;
        idx_r  <= 4'h0;
      end
      if (pend_r && ph_r == 3'h3) begin
        pend_r           <= 1'h0;
        act_r            <= 1'h1;
        hc_r             <= 6'h00;
        frame_pulse_n_in <= 1'h0;
        frame_eval_in    <= 1'h1;
      end
      if (act_r && ph_r == 3'h3 && hc_r == 6'h01) frame_pulse_n_in <= 1'h1;
      if (act_r && ph_r == 3'h3 && hc_r == eval_hp) frame_eval_in <= 1'h0;
      if (act_r && idx_r != 4'hf && (ph_r == 3'h1 || (ph_r == 3'h5 && hc_r == 6'h00))) idx_r <= idx_r + 4'h1;
    end
  end
  always_comb begin
    for (int s = 0; s < 32; s++) rx_stream_in[s] = code[s][idx_r];
  end
endmodule

// ===== isfo_pkg.sv
// Constants, register map and carrier types for the input stream frame offset block.
// Assumes a single pclk domain and an APB register port with 32-bit data.
package isfo_pkg;

  // Stream and field geometry
  localparam int STREAMS         = 32;
  localparam int FIELDS_PER_REG  = 4;
  localparam int FIELD_W         = 4;
  localparam int OFS_REGS        = 8;
  localparam int OFS_REG_W       = 16;
  localparam int HALF_BIT        = 0;
  localparam int WHOLE_LSB       = 1;
  localparam int WHOLE_W         = 3;

  // Register map, byte addresses
  localparam int ADDR_W                  = 12;
  localparam logic [11:0] ADDR_OFS_BASE  = 12'h000;
  localparam logic [11:0] ADDR_OFS_LAST  = 12'h01c;
  localparam logic [11:0] ADDR_CTRL      = 12'h020;
  localparam logic [11:0] ADDR_STAT      = 12'h024;

  // Field positions
  localparam int CTRL_START_BIT    = 0;
  localparam int STAT_COMPLETE_BIT = 13;
  localparam int STAT_PHASE_BIT    = 12;
  localparam int DELAY_W           = 12;

  // Reset values
  localparam logic [15:0] OFS_RESET  = 16'h0000;
  localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;

  // Half-period position counter after the frame pulse
  localparam int HALF_CNT_W              = 5;
  localparam logic [4:0] HALF_CNT_TOP    = 5'h10;
  localparam logic [11:0] DELAY_MAX      = 12'hfff;

  typedef struct packed {
    logic        complete;
    logic        phase;
    logic [11:0] count;
  } isfo_meas_type;

  typedef enum logic [1:0] {
    MEAS_IDLE = 2'b00,
    MEAS_ARM  = 2'b01,
    MEAS_RUN  = 2'b10,
    MEAS_DONE = 2'b11
  } isfo_meas_state_type;

endpackage

// ===== isfo_stream_rx.sv
// Per-stream receiver sampling point, set by its own 4-bit offset field.
// Assumes a shared half-period position and strobe from the frame timing logic.
`timescale 1ns/100ps
module isfo_stream_rx (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  // Frame timing
  input  wire logic       half_strobe,
  input  wire logic [4:0] cur_half,
  // Configuration and data
  input  wire logic [3:0] offset_field,
  input  wire logic       rx_level,
  // Captured data
  output logic            bit_r,
  output logic            valid_r,
  output logic            first_r
);

  logic [4:0] target_half;
  logic       at_or_after;
  logic       same_phase;

  // Nibble {whole, half} read as a number is the offset in half periods
  assign target_half = {1'b0, offset_field};
  assign at_or_after = cur_half >= target_half;
  assign same_phase  = cur_half[0] == offset_field[isfo_pkg::HALF_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_r   <= 1'b0;
      valid_r <= 1'b0;
      first_r <= 1'b0;
    end else if (ce) begin
      valid_r <= half_strobe && at_or_after && same_phase;
      first_r <= half_strobe && (cur_half == target_half);
      if (half_strobe && at_or_after && same_phase) begin
        bit_r <= rx_level;
      end
    end
  end

endmodule

// ===== isfo_sync3.sv
// Three-stage synchroniser for pin inputs, one per bit.
// Assumes the inputs are asynchronous to pclk; output moves once stages two and three agree.
`timescale 1ns/100ps
module isfo_sync3 #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  // Pins and stable result
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_r
);

  logic [W-1:0] meta_r;
  logic [W-1:0] stage2_r;
  logic [W-1:0] stage3_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r   <= RST_VAL;
      stage2_r <= RST_VAL;
      stage3_r <= RST_VAL;
    end else if (ce) begin
      meta_r   <= pin_in;
      stage2_r <= meta_r;
      stage3_r <= stage2_r;
    end
  end

  // Agreement filter keeps a single-cycle glitch out of the result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_r <= RST_VAL;
    end else if (ce) begin
      level_r <= (~(stage2_r ^ stage3_r) & stage3_r) | ((stage2_r ^ stage3_r) & level_r);
    end
  end

endmodule

// ===== isfo_top.sv
// Input stream frame offset alignment with frame delay measurement, APB register port.
// Assumes master clock, frame pulse, evaluation and stream pins are asynchronous to pclk.
//
// Functional notes
// - Reset clears all eight stream offset registers to zero.
// - One 4-bit field per stream 0..31; half bit lowest, three offset bits above.
// - Offset bits set when each receiver captures bit 0 of its stream.
// - Offset reaches up to +7.5 clock periods after the frame pulse.
// - Half bit zero puts the sampling point on a clock boundary.
// - Half bit one moves the sampling point a further half clock.
// - Shift equals whole offset periods plus half period when half bit set.
// - Phase bit is one if evaluation edge seen in clock high phase, else zero.
// - Start bit falling clears delay bits and completion flag; valid only when complete.
`timescale 1ns/100ps
module isfo_top #(
  parameter int NUM_STREAMS = 32
) (
  // Clock, reset, enable
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   ce,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Serial frame pins
  input  wire logic                   master_clock_in,
  input  wire logic                   frame_pulse_n_in,
  input  wire logic                   frame_eval_in,
  input  wire logic [NUM_STREAMS-1:0] rx_stream_in,
  // Captured stream data
  output logic      [NUM_STREAMS-1:0] rx_bit,
  output logic      [NUM_STREAMS-1:0] rx_valid,
  output logic      [NUM_STREAMS-1:0] rx_bit0,
  output logic                        frame_start
);

  localparam int NREGS = isfo_pkg::OFS_REGS;
  localparam int FPR   = isfo_pkg::FIELDS_PER_REG;
  localparam int FW    = isfo_pkg::FIELD_W;

  // The field packing and register map serve exactly one full set of streams
  if (NUM_STREAMS != isfo_pkg::STREAMS) begin : g_bad_streams
    $error("NUM_STREAMS must equal the packed register capacity");
  end

  // Register state
  logic [15:0]                    ofs_r [NREGS];
  logic                           start_r;
  logic                           start_prev_r;
  logic [31:0]                    prdata_r;
  logic                           pready_r;
  logic                           pslverr_r;
  isfo_pkg::isfo_meas_type        meas_r;
  isfo_pkg::isfo_meas_state_type  meas_state_r;
  isfo_pkg::isfo_meas_state_type  meas_state_nxt;

  // Frame timing state
  logic                           mclk_s;
  logic                           frame_n_s;
  logic                           eval_s;
  logic [NUM_STREAMS-1:0]         rx_s;
  logic                           mclk_prev_r;
  logic                           frame_n_prev_r;
  logic                           eval_prev_r;
  logic [4:0]                     half_cnt_r;
  logic [4:0]                     cur_half;
  logic                           frame_start_r;
  logic [11:0]                    delay_cnt_r;

  // Decoded events
  logic                           mclk_edge;
  logic                           mclk_rise;
  logic                           frame_fall;
  logic                           eval_fall;
  logic                           half_strobe;
  logic                           start_fall;
  logic                           start_rise;

  // APB decode
  logic                           access;
  logic                           complete_xfer;
  logic                           hit_ofs;
  logic                           hit_ctrl;
  logic                           hit_stat;
  logic [2:0]                     ofs_idx;
  logic [31:0]                    read_word;
  logic                           addr_err;

  // Pin synchronisers
  isfo_sync3 #(
    .W       (3),
    .RST_VAL (3'b010)
  ) u_sync_ctl (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .pin_in  ({master_clock_in, frame_pulse_n_in, frame_eval_in}),
    .level_r ({mclk_s, frame_n_s, eval_s})
  );

  isfo_sync3 #(
    .W       (NUM_STREAMS),
    .RST_VAL ('0)
  ) u_sync_rx (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .pin_in  (rx_stream_in),
    .level_r (rx_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_prev_r    <= 1'b0;
      frame_n_prev_r <= 1'b1;
      eval_prev_r    <= 1'b0;
    end else if (ce) begin
      mclk_prev_r    <= mclk_s;
      frame_n_prev_r <= frame_n_s;
      eval_prev_r    <= eval_s;
    end
  end

  assign mclk_edge  = mclk_s ^ mclk_prev_r;
  assign mclk_rise  = mclk_s & ~mclk_prev_r;
  assign frame_fall = ~frame_n_s & frame_n_prev_r;
  assign eval_fall  = ~eval_s & eval_prev_r;

  // Half-period position since the frame pulse; saturates but keeps its parity
  always_comb begin
    if (frame_fall) begin
      cur_half = 5'h00;
    end else if (half_cnt_r[4]) begin
      cur_half = {1'b1, 3'b000, ~half_cnt_r[0]};
    end else begin
      cur_half = half_cnt_r + 5'h01;
    end
  end

  assign half_strobe = frame_fall | mclk_edge;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt_r <= isfo_pkg::HALF_CNT_TOP;
    end else if (ce && half_strobe) begin
      half_cnt_r <= cur_half;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_start_r <= 1'b0;
    end else if (ce) begin
      frame_start_r <= frame_fall;
    end
  end

  assign frame_start = frame_start_r;

  // Per-stream receivers, each reading only its own nibble
  for (genvar s = 0; s < NUM_STREAMS; s++) begin : g_stream
    isfo_stream_rx u_rx (
      .pclk         (pclk),
      .presetn      (presetn),
      .ce           (ce),
      .half_strobe  (half_strobe),
      .cur_half     (cur_half),
      .offset_field (ofs_r[s / FPR][(s % FPR) * FW +: FW]),
      .rx_level     (rx_s[s]),
      .bit_r        (rx_bit[s]),
      .valid_r      (rx_valid[s]),
      .first_r      (rx_bit0[s])
    );
  end

  // APB: one wait state, pready from a flop
  assign access        = psel & penable;
  assign complete_xfer = access & pready_r;
  assign ofs_idx       = paddr[4:2];

  always_comb begin
    hit_ofs  = 1'b0;
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      hit_ofs = 1'b0;
    end else if (paddr <= isfo_pkg::ADDR_OFS_LAST) begin
      hit_ofs = 1'b1;
    end else if (paddr == isfo_pkg::ADDR_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (paddr == isfo_pkg::ADDR_STAT) begin
      hit_stat = 1'b1;
    end
  end

  // Status is read-only; writing it is an error
  assign addr_err = ~(hit_ofs | hit_ctrl | hit_stat) | (hit_stat & pwrite);

  always_comb begin
    read_word = isfo_pkg::DATA_ZERO;
    if (hit_ofs) begin
      read_word[15:0] = ofs_r[ofs_idx];
    end else if (hit_ctrl) begin
      read_word[isfo_pkg::CTRL_START_BIT] = start_r;
    end else if (hit_stat) begin
      read_word[isfo_pkg::STAT_COMPLETE_BIT] = meas_r.complete;
      read_word[isfo_pkg::STAT_PHASE_BIT]    = meas_r.phase;
      read_word[isfo_pkg::DELAY_W-1:0]       = meas_r.count;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= isfo_pkg::DATA_ZERO;
    end else if (ce) begin
      pready_r <= access & ~pready_r;
      if (access && !pready_r) begin
        pslverr_r <= addr_err;
        prdata_r  <= (pwrite || addr_err) ? isfo_pkg::DATA_ZERO : read_word;
      end else begin
        // Answer stands one cycle only; the master still holds access at the edge it samples pready
        pslverr_r <= 1'b0;
        prdata_r  <= isfo_pkg::DATA_ZERO;
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // Offset registers, written by byte lane
  for (genvar r = 0; r < NREGS; r++) begin : g_ofs
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ofs_r[r] <= isfo_pkg::OFS_RESET;
      end else if (ce && complete_xfer && pwrite && hit_ofs && (ofs_idx == r)) begin
        if (pstrb[0]) begin
          ofs_r[r][7:0] <= pwdata[7:0];
        end
        if (pstrb[1]) begin
          ofs_r[r][15:8] <= pwdata[15:8];
        end
      end
    end
  end

  // Start control bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r      <= 1'b0;
      start_prev_r <= 1'b0;
    end else if (ce) begin
      start_prev_r <= start_r;
      if (complete_xfer && pwrite && hit_ctrl && pstrb[0]) begin
        start_r <= pwdata[isfo_pkg::CTRL_START_BIT];
      end
    end
  end

  assign start_fall = start_prev_r & ~start_r;
  assign start_rise = ~start_prev_r & start_r;

  // Frame delay measurement: arm, wait for a frame, count to the evaluation edge
  always_comb begin
    meas_state_nxt = meas_state_r;
    case (meas_state_r)
      isfo_pkg::MEAS_IDLE: begin
        if (start_rise) begin
          meas_state_nxt = isfo_pkg::MEAS_ARM;
        end
      end
      isfo_pkg::MEAS_ARM: begin
        if (frame_fall) begin
          meas_state_nxt = isfo_pkg::MEAS_RUN;
        end
      end
      isfo_pkg::MEAS_RUN: begin
        if (eval_fall) begin
          meas_state_nxt = isfo_pkg::MEAS_DONE;
        end
      end
      isfo_pkg::MEAS_DONE: begin
        meas_state_nxt = isfo_pkg::MEAS_DONE;
      end
      default: begin
        meas_state_nxt = isfo_pkg::MEAS_IDLE;
      end
    endcase
    if (start_fall) begin
      meas_state_nxt = isfo_pkg::MEAS_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_state_r <= isfo_pkg::MEAS_IDLE;
    end else if (ce) begin
      meas_state_r <= meas_state_nxt;
    end
  end

  // Whole master clock periods since the frame pulse, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_cnt_r <= '0;
    end else if (ce) begin
      if (meas_state_r == isfo_pkg::MEAS_ARM && frame_fall) begin
        delay_cnt_r <= '0;
      end else if (meas_state_r == isfo_pkg::MEAS_RUN && mclk_rise && delay_cnt_r != isfo_pkg::DELAY_MAX) begin
        delay_cnt_r <= delay_cnt_r + 12'h001;
      end
    end
  end

  // Result fields hold zero until complete, so software never sees a partial count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_r <= '0;
    end else if (ce) begin
      if (start_fall) begin
        meas_r <= '0;
      end else if (meas_state_r == isfo_pkg::MEAS_RUN && eval_fall) begin
        meas_r.complete <= 1'b1;
        meas_r.phase    <= mclk_s;
        meas_r.count    <= delay_cnt_r;
      end
    end
  end

endmodule

// ===== tb.sv
// Self-checking bench: APB master, far-side model, offset and measurement model.
// Assumes ce and pstrb may be tied; master half period is eight pclk.
`timescale 1ns/100ps
module tb;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, go, er, phs, frame_start;
  logic              master_clock_in, frame_pulse_n_in, frame_eval_in;
  logic [11:0]       paddr, cnt;
  logic [31:0]       pwdata, prdata, rd, bv, rx_stream_in, rx_bit, rx_valid, rx_bit0;
  logic [5:0]        eval_hp;
  logic [31:0][15:0] code;
  logic [3:0]        v [32];
  int                n_fail, n_checks, t0;
  int                tb0 [32];
  isfo_top #(.NUM_STREAMS(32)) i_dut (
    .pclk, .presetn, .ce(1'h1), .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready,
    .pslverr, .master_clock_in, .frame_pulse_n_in, .frame_eval_in, .rx_stream_in, .rx_bit, .rx_valid,
    .rx_bit0, .frame_start
  );
  isfo_far_model i_far (
    .pclk, .presetn, .go, .eval_hp, .code, .master_clock_in, .frame_pulse_n_in, .frame_eval_in, .rx_stream_in
  );
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  task results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  function logic [31:0] word(int r);
    return {16'h0000, v[4*r+3], v[4*r+2], v[4*r+1], v[4*r]};
  endfunction
  // Watches pins for the expected count and phase, and the bit-0 captures
  task frame;
    logic pm, pf, pe, win;
    for (int s = 0; s < 32; s++) tb0[s] = -1;
    t0  = -1000;
    cnt = 12'h000;
    win = 1'h0;
    go <= 1'h1;
    pm = master_clock_in;
    pf = frame_pulse_n_in;
    pe = frame_eval_in;
    for (int c = 0; c < 200; c++) begin
      @(posedge pclk);
      go <= 1'h0;
      if (win && !pm && master_clock_in) cnt++;
      if (pf && !frame_pulse_n_in) win = 1'h1;
      if (pe && !frame_eval_in) begin
        win = 1'h0;
        phs = master_clock_in;
      end
      pm = master_clock_in;
      pf = frame_pulse_n_in;
      pe = frame_eval_in;
      if (frame_start === 1'h1) t0 = c;
      for (int s = 0; s < 32; s++) begin
        if (rx_bit0[s] === 1'h1) begin
          tb0[s] = c - t0;
          bv[s]  = rx_bit[s];
        end
      end
    end
  endtask
  initial begin
    n_fail   = 0;
    n_checks = 0;
    presetn  = 1'h0;
    psel     = 1'h0;
    penable  = 1'h0;
    pwrite   = 1'h0;
    paddr    = 12'h000;
    pwdata   = 32'h0000_0000;
    go       = 1'h0;
    eval_hp  = 6'h07;
    t0 = $urandom(96299);
    for (int s = 0; s < 32; s++) begin
      code[s] = 16'($urandom());
      v[s]    = 4'($urandom());
    end
    v[0]  = 4'h0;
    v[31] = 4'hf;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    for (int r = 0; r < 8; r++) begin
      apb(1'h0, 12'(r * 4), 32'h0000_0000);
      chk(rd, 32'h0000_0000);
    end
    for (int r = 0; r < 8; r++) begin
      apb(1'h1, 12'(r * 4), word(r) | 32'hffff_0000);
      apb(1'h0, 12'(r * 4), 32'h0000_0000);
      chk(rd, word(r));
    end
    apb(1'h0, 12'h028, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    apb(1'h0, 12'h002, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    apb(1'h1, isfo_pkg::ADDR_STAT, 32'hffff_ffff);
    chk({31'h0, er}, 32'h0000_0001);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) begin
        v[5] = {cnt[2:0], ~phs};
        eval_hp <= 6'h0a;
        apb(1'h1, 12'h004, word(1));
      end
      apb(1'h1, isfo_pkg::ADDR_CTRL, 32'h0000_0001);
      apb(1'h0, isfo_pkg::ADDR_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      frame();
      for (int s = 0; s < 32; s++) begin
        chk(32'(tb0[s]), (v[s] == 4'h0) ? 32'h0 : 32'(8 * v[s] - 4));
        chk({31'h0, bv[s]}, {31'h0, code[s][v[s]]});
      end
      apb(1'h0, isfo_pkg::ADDR_STAT, 32'h0000_0000);
      chk(rd, {18'h0, 1'h1, phs, cnt});
      apb(1'h1, isfo_pkg::ADDR_CTRL, 32'h0000_0000);
      apb(1'h0, isfo_pkg::ADDR_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
    end
    results();
  end
endmodule
